// file: rtl/tx_port_regs.vh
// Contract
// R1: in 10 or 100 Mbps MII mode the device drives a continuous transmit clock of 2.5 MHz or 25 MHz; at 100 Mbps it drives 5 MHz instead.
// R2: in MII mode the MAC launches data and error on the device-sourced transmit clock.
// R3: in GMII mode all eight data lanes are sampled on the MAC-sourced gigabit transmit clock.
// R4: lanes 3..0 are used in every mode, sampled on the gigabit clock in GMII/RGMII, else on ours; the code also uses the gigabit clock in MII at 1000 Mbps.
// R5: in GMII mode an asserted transmit error turns the sampled symbol into an invalid one.
// R6: in MII mode an asserted error gives one invalid symbol, then halt symbols until it drops.
// R7: in GMII and RGMII modes the MAC supplies a continuous 125 MHz gigabit transmit clock; the mac model supplies 1.25 MHz.
// R8: mode and speed select the sampling clock and lane width; upper lanes are ignored outside GMII.
`ifndef TX_PORT_REGS_VH
`define TX_PORT_REGS_VH

// interface modes
`define MODE_MII        2'h0
`define MODE_GMII       2'h1
`define MODE_RGMII      2'h2

// link speeds
`define SPEED_10        2'h0
`define SPEED_100       2'h1
`define SPEED_1000      2'h2

// symbol kinds on the line side
`define SYM_DATA        2'h0
`define SYM_INVALID     2'h1
`define SYM_HALT        2'h2

// timing
`define REF_CLK_HZ      10000000
`define TXCLK_10M_HZ    2500000
`define TXCLK_100M_HZ   25000000
`define HALF_CYC(f)     ((`REF_CLK_HZ / (2 * (f))) < 1 ? 1 : (`REF_CLK_HZ / (2 * (f))))
`define TXCLK_10M_HALF  `HALF_CYC(`TXCLK_10M_HZ)
`define TXCLK_100M_HALF `HALF_CYC(`TXCLK_100M_HZ)

`endif

// file: rtl/phy_mac_transmit_port.v
`timescale 1ns/1ps
`include "tx_port_regs.vh"

module phy_mac_transmit_port #(
    parameter HALF_10M  = `TXCLK_10M_HALF,
    parameter HALF_100M = `TXCLK_100M_HALF
) (
    input  wire       ref_clk,
    input  wire       rst,
    input  wire [1:0] mode,
    input  wire [1:0] speed,
    input  wire       gtx_clk,
    input  wire [7:0] tx_data,
    input  wire       tx_err,
    output reg        tx_clk_r,
    output reg  [7:0] sym_data_r,
    output reg  [1:0] sym_kind_r,
    output reg        sym_valid_r
);

    // ------------------------------------------------------------
    // local constants
    // ------------------------------------------------------------
    localparam LANES = 8;

    // one-hot states of the nibble error sequence
    localparam ERR_IDLE    = 3'b001;
    localparam ERR_INVALID = 3'b010;
    localparam ERR_HALT    = 3'b100;

    // ------------------------------------------------------------
    // mode decoding
    // ------------------------------------------------------------
    // true while the device sources the nibble clock itself
    function is_mii;
        input [1:0] m;
        input [1:0] s;
        begin
            is_mii = (m == `MODE_MII) && (s != `SPEED_1000);
        end
    endfunction

    // lanes that carry data; the upper nibble only counts in gmii
    function [7:0] lane_mask;
        input [1:0] m;
        begin
            if (m == `MODE_GMII) begin
                lane_mask = 8'hFF;
            end else begin
                lane_mask = 8'h0F;
            end
        end
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // every lane gets its own two-stage chain; the lanes are only
    // coherent because the mac holds them a full clock period
    reg  [1:0]       gtx_sync_r;
    reg              gtx_prev_r;
    reg              err_meta_r;
    reg              err_sync_r;
    wire [LANES-1:0] data_sync;

    always @(posedge ref_clk) begin
        if (rst) begin
            gtx_sync_r <= 2'h0;
            gtx_prev_r <= 1'b0;
            err_meta_r <= 1'b0;
            err_sync_r <= 1'b0;
        end else begin
            gtx_sync_r <= {gtx_sync_r[0], gtx_clk};
            gtx_prev_r <= gtx_sync_r[1];
            err_meta_r <= tx_err;
            err_sync_r <= err_meta_r;
        end
    end

    genvar lane;
    generate
        for (lane = 0; lane < LANES; lane = lane + 1) begin : g_lane_sync
            reg meta_r;
            reg sync_r;

            always @(posedge ref_clk) begin
                if (rst) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end else begin
                    meta_r <= tx_data[lane];
                    sync_r <= meta_r;
                end
            end

            assign data_sync[lane] = sync_r;
        end
    endgenerate

    // ------------------------------------------------------------
    // transmit clock source for 10/100 mii
    // ------------------------------------------------------------
    // a 25 MHz clock cannot be derived from a 10 MHz reference; the
    // half period then saturates at one cycle and the clock runs slow
    reg  [15:0] div_cnt_r;
    reg  [15:0] half_cyc;
    wire        mii_mode = is_mii(mode, speed);
    wire        div_wrap = (div_cnt_r + 16'h0001) >= half_cyc;

    always @* begin
        if (speed == `SPEED_10) begin
            half_cyc = HALF_10M[15:0];
        end else begin
            half_cyc = HALF_100M[15:0];
        end
    end

    // the clock is parked low outside mii so that the mac sees no
    // stray rising edge when the mode changes
    always @(posedge ref_clk) begin
        if (rst) begin
            div_cnt_r <= 16'h0000;
            tx_clk_r  <= 1'b0;
        end else if (!mii_mode) begin
            div_cnt_r <= 16'h0000;
            tx_clk_r  <= 1'b0;
        end else if (div_wrap) begin // see R1
            div_cnt_r <= 16'h0000;
            tx_clk_r  <= ~tx_clk_r;
        end else begin
            div_cnt_r <= div_cnt_r + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // sample points
    // ------------------------------------------------------------
    // the mac launches on our rising edge, so we take the lanes on the
    // falling edge, half a period later, to keep clear of its launch
    wire mii_take = mii_mode && tx_clk_r && div_wrap;           // see R2
    wire gtx_take = !mii_mode && gtx_sync_r[1] && !gtx_prev_r; // see R4
    wire gmii     = (mode == `MODE_GMII);

    // ------------------------------------------------------------
    // nibble error sequence
    // ------------------------------------------------------------
    // one invalid symbol, then halt for as long as the error stays up;
    // the sequence starts over once the error has dropped
    reg  [2:0] err_state_r;
    reg  [2:0] err_state_nxt;
    reg  [1:0] err_kind;

    always @* begin
        err_state_nxt = err_state_r;
        err_kind      = `SYM_DATA;
        if (!mii_mode) begin
            err_state_nxt = ERR_IDLE;
        end else if (mii_take) begin
            case (err_state_r)
                ERR_IDLE: begin
                    if (err_sync_r) begin
                        err_state_nxt = ERR_INVALID;
                        err_kind      = `SYM_INVALID; // see R6
                    end
                end
                ERR_INVALID: begin
                    if (err_sync_r) begin
                        err_state_nxt = ERR_HALT;
                        err_kind      = `SYM_HALT; // see R6
                    end else begin
                        err_state_nxt = ERR_IDLE;
                    end
                end
                ERR_HALT: begin
                    if (err_sync_r) begin
                        err_state_nxt = ERR_HALT;
                        err_kind      = `SYM_HALT; // see R6
                    end else begin
                        err_state_nxt = ERR_IDLE;
                    end
                end
                default: begin
                    err_state_nxt = ERR_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // symbol output
    // ------------------------------------------------------------
    // rgmii is taken as a single-edge nibble here; its error pin is
    // not acted on; gmii turns an error into invalid symbols, 10/100 mii into one invalid then halt symbols
    always @(posedge ref_clk) begin
        if (rst) begin
            sym_data_r  <= 8'h00;
            sym_kind_r  <= `SYM_DATA;
            sym_valid_r <= 1'b0;
            err_state_r <= ERR_IDLE;
        end else begin
            sym_valid_r <= mii_take | gtx_take; // see R8
            err_state_r <= err_state_nxt;
            if (gtx_take) begin
                sym_data_r <= data_sync & lane_mask(mode); // see R3, R8
                if (gmii && err_sync_r) begin
                    sym_kind_r <= `SYM_INVALID; // see R5
                end else begin
                    sym_kind_r <= `SYM_DATA;
                end
            end else if (mii_take) begin
                sym_data_r <= data_sync & lane_mask(`MODE_MII); // see R4
                sym_kind_r <= err_kind; // see R6
            end
        end
    end

endmodule // phy_mac_transmit_port

// file: testbench/tx_port_properties.sv
`timescale 1ns/1ps
module tx_port_properties (
    input wire       ref_clk,
    input wire       rst,
    input wire [1:0] mode,
    input wire [1:0] speed,
    input wire [7:0] tx_data,
    input wire       tx_err,
    input wire       tx_clk_r,
    input wire [7:0] sym_data_r,
    input wire [1:0] sym_kind_r,
    input wire       sym_valid_r
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    wire mii = mode == 2'h0 && speed != 2'h2;
    sequence s_bad; mii && sym_valid_r && sym_kind_r == 2'h1; endsequence
    sequence s_gap; (!sym_valid_r) [*3] ##1 sym_valid_r; endsequence
    property p_div; mii && speed == 2'h0 && $rose(tx_clk_r) |=>
        tx_clk_r ##1 (!tx_clk_r) [*2] ##1 tx_clk_r; endproperty
    property p_pace; mii |-> sym_valid_r == $fell(tx_clk_r); endproperty
    property p_off; !mii |-> !tx_clk_r; endproperty
    property p_lanes; !mii && sym_valid_r && !$past(tx_err, 3) |->
        sym_data_r == ($past(tx_data, 3) & (mode == 2'h1 ? 8'hFF : 8'h0F)); endproperty
    property p_gerr; mode == 2'h1 && sym_valid_r |-> sym_kind_r == {1'b0, $past(tx_err, 3)};
    endproperty
    property p_halt; s_bad ##1 s_gap |-> sym_kind_r != 2'h1; endproperty
    property p_rgerr; mode == 2'h2 && sym_valid_r |-> sym_kind_r == 2'h0; endproperty
    a_div: assert property (p_div) else $error("clock divide");
    a_pace: assert property (p_pace) else $error("sample pace");
    a_off: assert property (p_off) else $error("clock off");
    a_lanes: assert property (p_lanes) else $error("lanes");
    a_gerr: assert property (p_gerr) else $error("byte error");
    a_halt: assert property (p_halt) else $error("halt");
    a_rgerr: assert property (p_rgerr) else $error("rgmii error kind");
endmodule // tx_port_properties
bind phy_mac_transmit_port tx_port_properties tx_port_properties_i (.*);

// file: testbench/mac_model.sv
`timescale 1ns/1ps
module mac_model (
    input  wire       tx_clk_r,
    input  wire [1:0] mode,
    input  wire [1:0] speed,
    input  wire [7:0] d,
    input  wire       e,
    output reg        gtx_clk,
    output reg  [7:0] tx_data,
    output reg        tx_err
);
    // the gigabit clock stands still in 10/100 mii, so only our own
    // transmit clock launches data there
    wire mii = (mode == 2'h0) && (speed != 2'h2);
    initial begin
        {gtx_clk, tx_data, tx_err} = 10'h000;
        #137;
        forever #400 gtx_clk = !mii && !gtx_clk;
    end
    always @(negedge gtx_clk or posedge tx_clk_r) begin
        {tx_data, tx_err} <= {d, e};
    end
endmodule // mac_model

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic       ref_clk = 1'b0;
    logic       rst = 1'b1;
    logic [1:0] mode = 2'h1;
    logic [1:0] speed = 2'h2;
    logic [7:0] d = 8'h00;
    logic       e = 1'b0;
    wire        gtx_clk, tx_clk_r, tx_err, sym_valid_r;
    wire  [7:0] tx_data, sym_data_r;
    wire  [1:0] sym_kind_r;
    int         miscompares = 0;
    int         cmp_count = 0;
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    mac_model mac_model_i (.*);
    phy_mac_transmit_port phy_mac_transmit_port_i (.*);
    task give_verdict;
        $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task report(input logic [7:0] g, input logic [7:0] x);
        cmp_count++;
        if (g !== x) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task chk_data(input logic [7:0] g, input logic [7:0] x);
        report(g, x);
    endtask
    task chk_kind(input logic [1:0] g, input logic [1:0] x);
        report({6'h0, g}, {6'h0, x});
    endtask
    task chk_clk(input logic [7:0] g, input logic [7:0] x);
        report(g, x);
    endtask
    // counts the reference clock cycles for which the transmit clock stays high
    task clk_half(output logic [7:0] n);
        int k;
        n = 8'h00;
        k = 0;
        @(negedge ref_clk);
        while (tx_clk_r !== 1'b0 && k < 20) begin
            k++;
            @(negedge ref_clk);
        end
        while (tx_clk_r !== 1'b1 && k < 20) begin
            k++;
            @(negedge ref_clk);
        end
        while (tx_clk_r === 1'b1 && k < 20) begin
            k++;
            n++;
            @(negedge ref_clk);
        end
        if (k >= 20) begin
            miscompares++;
            give_verdict;
        end
    endtask
    task wv(input int k);
        int n;
        repeat (k) begin
            n = 0;
            @(negedge ref_clk);
            while (sym_valid_r !== 1'b1 && n < 60) begin
                n++;
                @(negedge ref_clk);
            end
            if (sym_valid_r !== 1'b1) begin
                miscompares++;
                give_verdict;
            end
        end
    endtask
    task setup(input logic [1:0] m, input logic [1:0] s, input logic [7:0] dv, input logic ev);
        @(negedge ref_clk);
        {mode, speed, d, e, rst} = {m, s, dv, ev, 1'b1};
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
    endtask
    task sc_gmii;
        setup(2'h1, 2'h2, 8'hA5, 1'b0);
        wv(2);
        chk_data(sym_data_r, 8'hA5);
        chk_kind(sym_kind_r, 2'h0);
        chk_clk({7'h0, tx_clk_r}, 8'h00);
        e = 1'b1;
        wv(2);
        chk_kind(sym_kind_r, 2'h1);
    endtask
    task sc_rgmii;
        setup(2'h2, 2'h2, 8'h5A, 1'b0);
        wv(2);
        chk_data(sym_data_r, 8'h0A);
        e = 1'b1;
        wv(2);
        chk_kind(sym_kind_r, 2'h0);
    endtask
    task sc_mii10;
        logic [7:0] h;
        setup(2'h0, 2'h0, 8'hF3, 1'b0);
        wv(3);
        chk_data(sym_data_r, 8'h03);
        clk_half(h);
        // 2.5 MHz from a 100 ns reference is high for two cycles
        chk_clk(h, 8'h02);
        e = 1'b1;
        for (int i = 0; i < 4 && sym_kind_r !== 2'h1; i++) wv(1);
        chk_kind(sym_kind_r, 2'h1);
        wv(1);
        chk_kind(sym_kind_r, 2'h2);
        e = 1'b0;
        wv(3);
        chk_kind(sym_kind_r, 2'h0);
    endtask
    task sc_mii100;
        logic [7:0] h;
        setup(2'h0, 2'h1, 8'h3C, 1'b0);
        wv(3);
        chk_data(sym_data_r, 8'h0C);
        clk_half(h);
        // the fastest clock the reference allows: one cycle high
        chk_clk(h, 8'h01);
    endtask
    initial begin
        repeat (8) @(negedge ref_clk);
        sc_gmii;
        sc_rgmii;
        sc_mii10;
        sc_mii100;
        give_verdict;
    end
endmodule // testbench
